// ### rtl/ocs_pkg.sv
// constants, mode enumeration and pin carrier for the oscillator mode clock select
package ocs_pkg;

   // ==========================================================
   // register bus geometry
   localparam int          ADDR_W           = 2;
   localparam int          DATA_W           = 8;
   localparam logic [1:0]  OFS_OSC_CONTROL  = 2'h0;
   localparam logic [1:0]  OFS_OSC_TUNING   = 2'h1;
   localparam logic [1:0]  OFS_OSC_STATUS   = 2'h2;

   // ==========================================================
   // field positions
   localparam int          FREQ_SEL_LSB     = 4;
   localparam int          FREQ_SEL_W       = 3;
   localparam int          SRC_SEL_BIT      = 7;
   localparam int          MULT_EN_BIT      = 6;
   localparam int          TUNE_W           = 5;
   localparam int          STAT_MULT_BIT    = 4;
   localparam int          STAT_INT8_BIT    = 5;
   localparam int          STAT_LFRC_BIT    = 6;
   localparam int          STAT_BUSY_BIT    = 7;

   // ==========================================================
   // reset values
   localparam logic [2:0]  FREQ_SEL_RST     = 3'h0;
   localparam logic [4:0]  TUNE_RST         = 5'h00;

   // ==========================================================
   // internal frequency select codes
   localparam logic [2:0]  FREQ_8MHZ        = 3'h7;
   localparam logic [2:0]  FREQ_4MHZ        = 3'h6;
   localparam logic [2:0]  FREQ_31KHZ       = 3'h0;

   // ==========================================================
   // mode field codes (fixed ones and a default table for the rest)
   localparam logic [3:0]  CODE_HS_X4       = 4'h6;
   localparam logic [3:0]  CODE_INT_CLKOUT  = 4'h9;
   localparam logic [3:0]  CODE_INT_GPIO    = 4'h8;
   localparam logic [3:0]  CODE_LOW_POWER   = 4'h0;
   localparam logic [3:0]  CODE_XTAL_RES    = 4'h1;
   localparam logic [3:0]  CODE_HS_XTAL     = 4'h2;
   localparam logic [3:0]  CODE_RESCAP_OUT  = 4'h3;
   localparam logic [3:0]  CODE_EXT_OUT     = 4'h4;
   localparam logic [3:0]  CODE_EXT_GPIO    = 4'h5;
   localparam logic [3:0]  CODE_RESCAP_GPIO = 4'h7;

   // ==========================================================
   // timing figures
   localparam int          FOSC_DIV         = 4;
   localparam int          PLL_MULT         = 4;
   localparam int          XTAL_PLL_MAX_MHZ = 10;
   localparam int          INT_PLL_MAX_MHZ  = 32;
   localparam int          LFDIV_BITS       = 8;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      MODE_LOW_POWER_XTAL  = 4'h0,
      MODE_XTAL_RESONATOR  = 4'h1,
      MODE_HS_XTAL         = 4'h2,
      MODE_HS_XTAL_X4      = 4'h3,
      MODE_RESCAP_CLKOUT   = 4'h4,
      MODE_RESCAP_GPIO     = 4'h5,
      MODE_INT_CLKOUT      = 4'h6,
      MODE_INT_DUAL_GPIO   = 4'h7,
      MODE_EXT_CLKOUT      = 4'h8,
      MODE_EXT_GPIO        = 4'h9
   } ocs_mode_type;

   typedef struct packed {
      logic value;
      logic oe;
   } ocs_pin_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic              wrStrobe;
      logic              rdStrobe;
   } ocs_bus_type;

endpackage

// ### rtl/ocs_glitchless_mux.sv
// glitch-free clock source selector working on sampled source levels
`timescale 1ns/1ns
module ocs_glitchless_mux
   import ocs_pkg::*;
#(
   parameter int NUM_SRC = 5,
   parameter int SEL_W   = 3
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_b,
   // sources and selection
   input  wire logic [NUM_SRC-1:0] srcLevel,
   input  wire logic [SEL_W-1:0]   reqSel,
   // selected clock
   output logic                    devClk,
   output logic                    switchBusy
);

   // ==========================================================
   // elaboration check
   generate
      if (NUM_SRC < 2 || (1 << SEL_W) < NUM_SRC) begin : g_bad
         $error("ocs_glitchless_mux: select too narrow for source count");
      end
   endgenerate

   logic [SEL_W-1:0] curSel;
   logic             gateOn;
   logic             curLevel;
   logic             reqLevel;

   assign curLevel = srcLevel[curSel];
   assign reqLevel = srcLevel[reqSel];

   // ==========================================================
   // gate off old source while low, then gate on new one while low
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         curSel <= '0;
         gateOn <= 1'b0;
      end else if (reqSel != curSel) begin
         if (gateOn && !curLevel) begin
            gateOn <= 1'b0;           // never cut a high phase
         end else if (!gateOn && !reqLevel) begin
            curSel <= reqSel;         // join new source in its low phase
            gateOn <= 1'b1;
         end
      end else if (!gateOn && !curLevel) begin
         gateOn <= 1'b1;
      end
   end

   // ==========================================================
   // registered output so the gate never shaves a pulse
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         devClk <= 1'b0;
      end else begin
         devClk <= gateOn & curLevel;
      end
   end

   assign switchBusy = (reqSel != curSel) || !gateOn;

endmodule

// ### rtl/ocs_clock_select.sv
// oscillator mode decode, pin muxing, internal source control and device clock select
//
// Overview of operation
// - four-bit mode field picks one of ten modes
// - crystal modes dedicate both oscillator pins
// - high-speed crystal mode accepts external clock too
// - external clock modes need no start-up delay
// - external clock mode outputs device clock over four
// - external clock gpio mode frees out pin
// - resistor-capacitor mode outputs clock over four
// - resistor-capacitor gpio mode frees out pin
// - internal clkout mode: bit6 clock, bit7 gpio
// - internal dual gpio mode: both pins gpio
// - x4 crystal mode multiplies crystal by four
// - only x4 mode code routes crystal to multiplier
// - software multiplier enable ignored in x4 mode
// - internal modes let software enable multiplier
// - 8 MHz source feeds selector and postscaler
// - 8 MHz source runs for 125k-8M and for the 8 MHz/256 option
// - low-frequency source runs when selected or needed
// - frequency select picks direct, low-rc or postscaled
// - internal multiplier only at 4 or 8 MHz
// - enable bit forced and read zero when unavailable
// - source bit picks 8 MHz/256 or low-rc
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module ocs_clock_select
   import ocs_pkg::*;
#(
   parameter logic [3:0] CODE_LOW_POWER_P   = CODE_LOW_POWER,
   parameter logic [3:0] CODE_XTAL_RES_P    = CODE_XTAL_RES,
   parameter logic [3:0] CODE_HS_XTAL_P     = CODE_HS_XTAL,
   parameter logic [3:0] CODE_RESCAP_OUT_P  = CODE_RESCAP_OUT,
   parameter logic [3:0] CODE_RESCAP_GPIO_P = CODE_RESCAP_GPIO,
   parameter logic [3:0] CODE_EXT_OUT_P     = CODE_EXT_OUT,
   parameter logic [3:0] CODE_EXT_GPIO_P    = CODE_EXT_GPIO
) (
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // configuration strap, sampled once after reset
   input  wire logic [3:0]        oscModeCfgField,
   // register port
   input  wire ocs_bus_type       bus,
   output logic [DATA_W-1:0]      rdData,
   // raw clock sources from the analog side
   input  wire logic              oscPinInLevel,
   input  wire logic              multiplierClk,
   input  wire logic              mainInternal8mhzSource,
   input  wire logic              lowFreqInternalRcSource,
   // features that keep the low-frequency source alive
   input  wire logic              powerUpTimerEn,
   input  wire logic              failSafeMonitorEn,
   input  wire logic              watchdogEn,
   input  wire logic              twoSpeedStartEn,
   // general-purpose port side for the two shared pins
   input  wire ocs_pin_type       portABit6Drive,
   input  wire ocs_pin_type       portABit7Drive,
   output logic                   portABit6In,
   output logic                   portABit7In,
   // pad side for the two oscillator pins
   input  wire logic              oscPinOutLevel,
   output ocs_pin_type            oscPinInPad,
   output ocs_pin_type            oscPinOutPad,
   // analog controls
   output logic                   crystalToMultiplier,
   output logic                   multiplierEnable,
   output logic                   mainInternalEnable,
   output logic                   lowFreqInternalEnable,
   output logic [TUNE_W-1:0]      tuneCode,
   output logic                   oscStartupRequired,
   // device clock
   output logic                   devClk
);

   // ==========================================================
   // elaboration check on the code table
   generate
      if (CODE_LOW_POWER_P == CODE_HS_X4 || CODE_XTAL_RES_P == CODE_HS_X4 ||
          CODE_HS_XTAL_P == CODE_HS_X4 || CODE_RESCAP_OUT_P == CODE_HS_X4 ||
          CODE_RESCAP_GPIO_P == CODE_HS_X4 || CODE_EXT_OUT_P == CODE_HS_X4 ||
          CODE_EXT_GPIO_P == CODE_HS_X4) begin : g_bad_code
         $error("ocs_clock_select: code table collides with the x4 crystal code");
      end
   endgenerate

   localparam int          NUM_SRC       = 5;
   localparam int          SEL_W         = 3;
   localparam logic [2:0]  SRC_PRIMARY   = 3'h0;
   localparam logic [2:0]  SRC_MULT      = 3'h1;
   localparam logic [2:0]  SRC_INT_DIR   = 3'h2;
   localparam logic [2:0]  SRC_INT_POST  = 3'h3;
   localparam logic [2:0]  SRC_LOWFREQ   = 3'h4;

   // ==========================================================
   // mode decode from the strap
   function automatic ocs_mode_type decodeMode(input logic [3:0] code);
      case (code)
         CODE_HS_X4:         return MODE_HS_XTAL_X4;
         CODE_INT_CLKOUT:    return MODE_INT_CLKOUT;
         CODE_INT_GPIO:      return MODE_INT_DUAL_GPIO;
         CODE_XTAL_RES_P:    return MODE_XTAL_RESONATOR;
         CODE_HS_XTAL_P:     return MODE_HS_XTAL;
         CODE_RESCAP_OUT_P:  return MODE_RESCAP_CLKOUT;
         CODE_RESCAP_GPIO_P: return MODE_RESCAP_GPIO;
         CODE_EXT_OUT_P:     return MODE_EXT_CLKOUT;
         CODE_EXT_GPIO_P:    return MODE_EXT_GPIO;
         default:            return MODE_LOW_POWER_XTAL;
      endcase
   endfunction

   logic [3:0]        modeCode;
   logic              cfgCaptured;
   ocs_mode_type      mode;
   // strap is caught on the first edge after release, never under reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         modeCode    <= 4'h0;
         cfgCaptured <= 1'b0;
      end else if (!cfgCaptured) begin
         modeCode    <= oscModeCfgField;
         cfgCaptured <= 1'b1;
      end
   end

   assign mode = decodeMode(modeCode);

   // ==========================================================
   // mode classes
   logic crystalMode;
   logic internalMode;
   logic clkoutOnPinOut;
   logic pinOutIsGpio;
   logic pinInIsGpio;
   assign crystalMode    = (mode == MODE_LOW_POWER_XTAL) || (mode == MODE_XTAL_RESONATOR) ||
                           (mode == MODE_HS_XTAL) || (mode == MODE_HS_XTAL_X4);
   assign internalMode   = (mode == MODE_INT_CLKOUT) || (mode == MODE_INT_DUAL_GPIO);
   assign clkoutOnPinOut = (mode == MODE_EXT_CLKOUT) || (mode == MODE_RESCAP_CLKOUT) ||
                           (mode == MODE_INT_CLKOUT);
   assign pinOutIsGpio   = (mode == MODE_EXT_GPIO) || (mode == MODE_RESCAP_GPIO) ||
                           (mode == MODE_INT_DUAL_GPIO);
   assign pinInIsGpio    = internalMode;

   // ==========================================================
   // two-flop synchronisers for the five source and pin levels arriving from outside
   logic [5:1] syncA;
   logic [5:1] syncB;
   logic       int8Prev;
   logic       devClkPrev;
   // bit numbers match the tap names below
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         syncA <= 5'h00;
         syncB <= 5'h00;
      end else begin
         syncA <= {oscPinOutLevel, multiplierClk, mainInternal8mhzSource,
                   lowFreqInternalRcSource, oscPinInLevel};
         syncB <= syncA;
      end
   end
   logic pinInSync;
   logic lowFreqSync;
   logic int8Sync;
   logic multSync;
   logic pinOutSync;
   assign pinInSync   = syncB[1];
   assign lowFreqSync = syncB[2];
   assign int8Sync    = syncB[3];
   assign multSync    = syncB[4];
   assign pinOutSync  = syncB[5];

   // ==========================================================
   // register file
   logic [FREQ_SEL_W-1:0] internalFreqSelect;
   logic                  lowFreqSourceSelect;
   logic                  swMultiplierEnable;
   logic [TUNE_W-1:0]     tune;
   logic                  multAvailable;
   logic                  switchBusy;
   // software enable exists only in the internal modes
   assign multAvailable = internalMode;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         internalFreqSelect <= FREQ_SEL_RST;
      end else if (bus.wrStrobe && bus.addr == OFS_OSC_CONTROL) begin
         internalFreqSelect <= bus.wrData[FREQ_SEL_LSB +: FREQ_SEL_W];
      end
   end
   // tuning register; the enable bit is held at zero where unusable
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         lowFreqSourceSelect <= 1'b0;
         swMultiplierEnable  <= 1'b0;
         tune                <= TUNE_RST;
      end else begin
         if (bus.wrStrobe && bus.addr == OFS_OSC_TUNING) begin
            lowFreqSourceSelect <= bus.wrData[SRC_SEL_BIT];
            tune                <= bus.wrData[TUNE_W-1:0];
         end
         if (!multAvailable) begin
            swMultiplierEnable <= 1'b0;
         end else if (bus.wrStrobe && bus.addr == OFS_OSC_TUNING) begin
            swMultiplierEnable <= bus.wrData[MULT_EN_BIT];
         end
      end
   end
   assign tuneCode = tune;

   // ==========================================================
   // multiplier control
   logic intMultActive;
   assign intMultActive = internalMode && swMultiplierEnable &&
                          (internalFreqSelect == FREQ_8MHZ ||
                           internalFreqSelect == FREQ_4MHZ);
   assign crystalToMultiplier = (mode == MODE_HS_XTAL_X4);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         multiplierEnable <= 1'b0;
      end else begin
         multiplierEnable <= crystalToMultiplier || intMultActive;
      end
   end

   // ==========================================================
   // internal source enables
   logic lowFreqSelected;
   assign lowFreqSelected = internalMode && internalFreqSelect == FREQ_31KHZ &&
                            !lowFreqSourceSelect;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mainInternalEnable    <= 1'b0;
         lowFreqInternalEnable <= 1'b0;
      end else begin
         // the /256 option also needs the 8 MHz source to run
         mainInternalEnable    <= internalMode &&
                                  (internalFreqSelect != FREQ_31KHZ ||
                                   lowFreqSourceSelect);
         lowFreqInternalEnable <= lowFreqSelected || powerUpTimerEn || failSafeMonitorEn ||
                                  watchdogEn || twoSpeedStartEn;
      end
   end

   // crystal modes need the start-up timer, external clock modes do not
   assign oscStartupRequired = crystalMode;

   // ==========================================================
   // postscaler on the 8 MHz source
   logic [LFDIV_BITS-1:0] postCount;
   logic                  postClk;
   logic                  int8Rise;
   assign int8Rise = int8Sync && !int8Prev;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         int8Prev  <= 1'b0;
         postCount <= '0;
      end else begin
         int8Prev <= int8Sync;
         if (int8Rise) begin
            postCount <= postCount + 1'b1;
         end
      end
   end
   // tap per select code: 110 -> /2 ... 001 -> /64, 000 -> /256
   always_comb begin
      case (internalFreqSelect)
         3'h6:    postClk = postCount[0];
         3'h5:    postClk = postCount[1];
         3'h4:    postClk = postCount[2];
         3'h3:    postClk = postCount[3];
         3'h2:    postClk = postCount[4];
         3'h1:    postClk = postCount[5];
         default: postClk = postCount[LFDIV_BITS-1];
      endcase
   end

   // ==========================================================
   // source selection
   logic [SEL_W-1:0] reqSel;
   always_comb begin
      if (crystalToMultiplier || intMultActive) begin
         reqSel = SRC_MULT;
      end else if (!internalMode) begin
         reqSel = SRC_PRIMARY;
      end else if (internalFreqSelect == FREQ_8MHZ) begin
         reqSel = SRC_INT_DIR;
      end else if (lowFreqSelected) begin
         reqSel = SRC_LOWFREQ;
      end else begin
         reqSel = SRC_INT_POST;
      end
   end

   ocs_glitchless_mux #(
      .NUM_SRC (NUM_SRC),
      .SEL_W   (SEL_W)
   ) u_mux (
      .core_clk   (core_clk),
      .rst_b      (rst_b),
      .srcLevel   ({lowFreqSync, postClk, int8Sync, multSync, pinInSync}),
      .reqSel     (reqSel),
      .devClk     (devClk),
      .switchBusy (switchBusy)
   );

   // ==========================================================
   // device clock divided by four for the out pin
   logic [1:0] quarterCount;
   logic       quarterClk;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         devClkPrev   <= 1'b0;
         quarterCount <= 2'h0;
         quarterClk   <= 1'b0;
      end else begin
         devClkPrev <= devClk;
         if (devClk && !devClkPrev) begin
            quarterCount <= quarterCount + 2'h1;
         end
         quarterClk <= quarterCount[1];
      end
   end

   // ==========================================================
   // pad muxing; crystal modes leave both pads to the oscillator
   always_comb begin
      oscPinOutPad = '{value: 1'b0, oe: 1'b0};
      if (clkoutOnPinOut) begin
         oscPinOutPad = '{value: quarterClk, oe: 1'b1};
      end else if (pinOutIsGpio) begin
         oscPinOutPad = portABit6Drive;
      end
   end
   always_comb begin
      oscPinInPad = '{value: 1'b0, oe: 1'b0};
      if (pinInIsGpio) begin
         oscPinInPad = portABit7Drive;
      end
   end
   // gpio reads return zero while the pin belongs to the oscillator
   assign portABit6In = pinOutIsGpio && pinOutSync;
   assign portABit7In = pinInIsGpio && pinInSync;

   // ==========================================================
   // read port; data stand only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdData <= '0;
      end else if (bus.rdStrobe) begin
         case (bus.addr)
            OFS_OSC_CONTROL: rdData <= {1'b0, internalFreqSelect, 4'h0};
            OFS_OSC_TUNING:  rdData <= {lowFreqSourceSelect, swMultiplierEnable,
                                        1'b0, tune};
            OFS_OSC_STATUS:  rdData <= {switchBusy, lowFreqInternalEnable,
                                        mainInternalEnable, multiplierEnable, modeCode};
            default:         rdData <= '0;
         endcase
      end else begin
         rdData <= '0;
      end
   end

endmodule

// ### tb/ocs_monitor.sv
// port assertions for the oscillator mode clock select
`timescale 1ns/1ns
module ocs_monitor
   import ocs_pkg::*;
(
   // clock and reset
   input wire logic              core_clk,
   input wire logic              rst_b,
   // strap and features
   input wire logic [3:0]        oscModeCfgField,
   input wire logic              powerUpTimerEn,
   input wire logic              failSafeMonitorEn,
   input wire logic              watchdogEn,
   input wire logic              twoSpeedStartEn,
   // pins
   input wire ocs_pin_type       portABit6Drive,
   input wire ocs_pin_type       portABit7Drive,
   input wire ocs_pin_type       oscPinInPad,
   input wire ocs_pin_type       oscPinOutPad,
   // controls
   input wire logic              crystalToMultiplier,
   input wire logic              multiplierEnable,
   input wire logic              lowFreqInternalEnable,
   input wire logic              oscStartupRequired
);
   logic [1:0] age;
   logic [3:0] mode;
   wire ok = age == 2'h3;
   wire xt = !(mode inside {4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9});
   wire in = mode inside {4'h8, 4'h9};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // =========================================
   // strap capture
   // outputs only settle two edges after release, so checks wait for age 3
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         age  <= 2'h0;
         mode <= 4'h0;
      end else begin
         if (age == 2'h0)
            mode <= oscModeCfgField;
         if (age != 2'h3)
            age <= age + 2'h1;
      end
   end
   // =========================================
   // assertions
   route_x4_a: assert property (ok |-> crystalToMultiplier == (mode == 4'h6))
      else $error("crystal routed to multiplier in wrong mode");
   mult_x4_a: assert property (ok && mode == 4'h6 |-> multiplierEnable)
      else $error("multiplier off in x4 mode");
   mult_off_a: assert property (ok && !in && mode != 4'h6 |-> !multiplierEnable)
      else $error("multiplier on in a mode without it");
   startup_a: assert property (ok |-> oscStartupRequired == xt)
      else $error("start-up request wrong for mode");
   xtal_pins_a: assert property (ok && xt |-> !oscPinOutPad.oe && !oscPinInPad.oe)
      else $error("oscillator pin driven in crystal mode");
   gpio_out_a: assert property (ok && mode inside {4'h5, 4'h7, 4'h8} |-> oscPinOutPad == portABit6Drive)
      else $error("out pin not following port drive");
   clkout_oe_a: assert property (ok && mode inside {4'h3, 4'h4, 4'h9} |-> oscPinOutPad.oe)
      else $error("quarter clock not driven");
   in_pin_a: assert property (ok && in |-> oscPinInPad == portABit7Drive)
      else $error("in pin not following port drive");
   lf_feat_a: assert property (ok && (powerUpTimerEn || failSafeMonitorEn || watchdogEn || twoSpeedStartEn) |=> lowFreqInternalEnable)
      else $error("low-frequency source off while a feature needs it");
   cover property (ok && in && multiplierEnable);
   cover property (ok && !in && oscPinOutPad.oe && oscPinOutPad.value);
   cover property (ok && mode == 4'h6);
endmodule
bind ocs_clock_select ocs_monitor u_ocs_monitor (.core_clk, .rst_b, .oscModeCfgField,
   .powerUpTimerEn, .failSafeMonitorEn, .watchdogEn, .twoSpeedStartEn, .portABit6Drive,
   .portABit7Drive, .oscPinInPad, .oscPinOutPad, .crystalToMultiplier, .multiplierEnable,
   .lowFreqInternalEnable, .oscStartupRequired);

// ### tb/ocs_osc_model.sv
// behavioural clock sources at the far side of the block
`timescale 1ns/1ns
module ocs_osc_model (
   // raw source levels
   output logic xtal,
   output logic mult,
   output logic int8,
   output logic lfrc
);
   // free-running oscillators; the multiplier runs four times the crystal
   initial begin
      xtal = 1'b0;
      mult = 1'b0;
      int8 = 1'b0;
      lfrc = 1'b0;
   end
   always #100 xtal = ~xtal;
   always #25 mult = ~mult;
   always #62 int8 = ~int8;
   always #320 lfrc = ~lfrc; // lf source scaled up to keep runs short
endmodule

// ### tb/tb.sv
// self-checking bench for the oscillator mode clock select
`timescale 1ns/1ns
module tb;
   import ocs_pkg::*;
   logic              core_clk, rst_b, in6, in7, xtal, mult, int8, lfrc;
   logic              x4, mEn, iEn, lEn, stUp, devClk;
   logic [3:0]        cfg, feat;
   logic [4:0]        tune;
   logic [DATA_W-1:0] rdData;
   ocs_bus_type       bus;
   ocs_pin_type       p6, p7, inPad, outPad;
   int                bad_count, compares;
   // =========================================
   // pads: a driven pin shows its drive, the out pin has a pull-up
   wire inLvl  = inPad.oe ? inPad.value : xtal;
   wire outLvl = outPad.oe ? outPad.value : 1'b1;
   ocs_clock_select u_ocs_clock_select (.core_clk, .rst_b, .oscModeCfgField(cfg), .bus,
      .rdData, .oscPinInLevel(inLvl), .multiplierClk(mult), .mainInternal8mhzSource(int8),
      .lowFreqInternalRcSource(lfrc), .powerUpTimerEn(feat[0]), .failSafeMonitorEn(feat[1]),
      .watchdogEn(feat[2]), .twoSpeedStartEn(feat[3]), .portABit6Drive(p6),
      .portABit7Drive(p7), .portABit6In(in6), .portABit7In(in7), .oscPinOutLevel(outLvl),
      .oscPinInPad(inPad), .oscPinOutPad(outPad), .crystalToMultiplier(x4),
      .multiplierEnable(mEn), .mainInternalEnable(iEn), .lowFreqInternalEnable(lEn),
      .tuneCode(tune), .oscStartupRequired(stUp), .devClk);
   ocs_osc_model u_ocs_osc_model (.xtal, .mult, .int8, .lfrc);
   // 50 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // =========================================
   // shared tasks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic boot(input logic [3:0] m);
      cfg <= m;
      rst_b <= 1'b0;
      step(16);
      rst_b <= 1'b1;
      step(4);
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      bus <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
      step(1);
      bus.wrStrobe <= 1'b0;
      step(1);
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      bus <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
      step(1);
      d = rdData;
      bus.rdStrobe <= 1'b0;
      step(1);
   endtask
   // =========================================
   // scenarios
   task automatic s_modes();
      logic [7:0] d;
      for (int m = 0; m < 12; m++) begin
         boot(m[3:0]);
         rd(OFS_OSC_STATUS, d);
         if (m < 10) chk("mode", m[7:0], {4'h0, d[3:0]});
         chk("x4 route", {7'h0, m == 6}, {7'h0, x4});
         chk("startup", {7'h0, m inside {0, 1, 2, 6} || m > 9}, {7'h0, stUp});
      end
   endtask
   task automatic s_pll();
      logic [7:0] d;
      boot(CODE_INT_CLKOUT);
      wr(OFS_OSC_CONTROL, 8'h70);
      wr(OFS_OSC_TUNING, 8'h40);
      step(2);
      chk("mult f7", 8'h01, {7'h0, mEn});
      wr(OFS_OSC_CONTROL, 8'h50);
      step(2);
      chk("mult f5", 8'h00, {7'h0, mEn});
      boot(CODE_HS_X4);
      wr(OFS_OSC_TUNING, 8'h5F);
      rd(OFS_OSC_TUNING, d);
      chk("tuning", 8'h1F, d);
      chk("tune code", 8'h1F, {3'h0, tune});
   endtask
   task automatic s_int();
      boot(CODE_INT_GPIO);
      wr(OFS_OSC_TUNING, 8'h00);
      step(2);
      chk("lf rc", 8'h02, {6'h0, lEn, iEn});
      wr(OFS_OSC_TUNING, 8'h80);
      feat <= 4'h4;
      step(2);
      chk("div256", 8'h03, {6'h0, lEn, iEn});
      feat <= 4'h0;
      wr(OFS_OSC_CONTROL, 8'h70);
      step(2);
      chk("8 MHz", 8'h01, {6'h0, lEn, iEn});
   endtask
   task automatic s_clkout(input logic [3:0] m);
      int dev = 0;
      int out = 0;
      logic pd;
      logic po;
      boot(m);
      pd = devClk;
      po = outPad.value;
      repeat (400) begin
         step(1);
         dev += int'(devClk && !pd);
         out += int'(outPad.value && !po);
         pd = devClk;
         po = outPad.value;
      end
      chk("quarter", 8'h01, {7'h0, out > 5 && dev >= 4 * out - 4 && dev <= 4 * out + 4});
   endtask
   task automatic s_gpio(input logic [3:0] m);
      for (int v = 0; v < 2; v++) begin
         p6 <= '{value: v[0], oe: 1'b1};
         p7 <= '{value: v[0], oe: 1'b1};
         if (v == 0) boot(m);
         step(4);
         chk("bit6 in", {7'h0, v[0]}, {7'h0, in6});
         if (m == CODE_INT_GPIO) chk("bit7 in", {7'h0, v[0]}, {7'h0, in7});
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      rst_b = 1'b0;
      cfg = 4'h0;
      feat = 4'h0;
      bus = '0;
      p6 = '0;
      p7 = '0;
      bad_count = 0;
      compares = 0;
      s_modes();
      s_pll();
      s_int();
      s_clkout(CODE_EXT_OUT);
      s_clkout(CODE_RESCAP_OUT);
      s_gpio(CODE_EXT_GPIO);
      s_gpio(CODE_RESCAP_GPIO);
      s_gpio(CODE_INT_GPIO);
      wrap_up();
   end
endmodule
